// File: pkg/icg_pkg.sv
package icg_pkg;
    // register indices, byte address is four times the index
    localparam logic [11:0] IDX_CON2     = 12'hFC5;
    localparam logic [11:0] IDX_CTRL     = 12'hFC0;
    localparam logic [11:0] IDX_STAT     = 12'hFC1;
    localparam logic [11:0] IDX_OWN_ADDR = 12'hFC2;
    localparam logic [11:0] IDX_BUF      = 12'hFC3;
    localparam logic [11:0] IDX_INT_STAT = 12'hFC4;
    localparam logic [11:0] IDX_INT_MASK = 12'hFC6;

    // i2c_master_control_two field positions
    localparam int B_GENERAL_CALL_ENABLE  = 7;
    localparam int B_ACKST = 6;
    localparam int B_ACK_DATA_VALUE = 5;
    localparam int B_ACK_SEQUENCE_ENABLE = 4;
    localparam int B_MASTER_RECEIVE_ENABLE  = 3;
    localparam int B_PEN   = 2;
    localparam int B_REPEATED_START_ENABLE  = 1;
    localparam int B_SEN   = 0;

    // control register fields
    localparam int B_CTL_EN     = 0;
    localparam int B_CTL_MASTER = 1;
    localparam int B_CTL_TENBIT = 2;

    // status register fields
    localparam int B_ST_BF    = 0;
    localparam int B_ST_UA    = 1;
    localparam int B_ST_START = 2;
    localparam int B_ST_STOP  = 3;
    localparam int B_ST_BUSY  = 4;
    localparam int B_ST_GCHIT = 5;

    // interrupt status / mask fields
    localparam int B_IRQ_SPIF  = 0;
    localparam int B_IRQ_START = 1;
    localparam int B_IRQ_STOP  = 2;
    localparam int IRQ_W       = 3;

    // reset values
    localparam logic [7:0] RST_CON2 = 8'h00;
    localparam logic [2:0] RST_CTRL = 3'h0;
    localparam logic [7:0] RST_OWN  = 8'h00;
    localparam logic [7:0] RST_BUF  = 8'h00;
    localparam logic [2:0] RST_MASK = 3'h0;

    // address constants
    localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
    localparam logic [4:0] TEN_BIT_HDR   = 5'h1E;

    // timing: quarter of an scl period, rounded down to clock cycles
    localparam int CLK_NS  = 25;
    localparam int QTR_NS  = 2500;
    localparam int QTR_CYC = (QTR_NS / CLK_NS < 1) ? 1 : QTR_NS / CLK_NS;

    typedef enum logic [2:0] {
        M_IDLE   = 3'b000,
        M_START  = 3'b001,
        M_TX     = 3'b011,
        M_RX     = 3'b010,
        M_ACK    = 3'b110,
        M_STOP   = 3'b111,
        M_RSTART = 3'b101
    } icg_mstate_t;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_ADDR  = 2'b01,
        S_ADDR2 = 2'b11,
        S_DATA  = 2'b10
    } icg_sstate_t;
endpackage : icg_pkg

// File: core/icg_core.sv
`timescale 1ns/1ps
module icg_core (
    // clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [15:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // two-wire link
    input  wire logic        serial_clock_line_i,
    output logic             serial_clock_line_o,
    output logic             serial_clock_line_oe_o,
    input  wire logic        serial_data_line_i,
    output logic             serial_data_line_o,
    output logic             serial_data_line_oe_o,
    // interrupt
    output logic             irq_o
);
    // register state
    logic [7:0]               con2_r;      // general_call_enable, ack_status, ack_data_value
    logic [2:0]               ctrl_r;
    logic [7:0]               own_r;
    logic [7:0]               buf_r;
    logic                     bf_r;
    logic                     ua_r;
    logic                     st_start_r;
    logic                     st_stop_r;
    logic                     gchit_r;
    logic [icg_pkg::IRQ_W-1:0] irq_r;
    logic [icg_pkg::IRQ_W-1:0] mask_r;
    logic [31:0]              prdata_r;

    // bus decode
    wire        setup_w  = psel_i & ~penable_i;
    wire        access_w = psel_i & penable_i;
    wire [13:0] idx_w    = paddr_i[15:2];
    wire        hit_con2 = idx_w == {2'b00, icg_pkg::IDX_CON2};
    wire        hit_ctrl = idx_w == {2'b00, icg_pkg::IDX_CTRL};
    wire        hit_stat = idx_w == {2'b00, icg_pkg::IDX_STAT};
    wire        hit_own  = idx_w == {2'b00, icg_pkg::IDX_OWN_ADDR};
    wire        hit_buf  = idx_w == {2'b00, icg_pkg::IDX_BUF};
    wire        hit_ist  = idx_w == {2'b00, icg_pkg::IDX_INT_STAT};
    wire        hit_msk  = idx_w == {2'b00, icg_pkg::IDX_INT_MASK};
    wire        mapped_w = hit_con2 | hit_ctrl | hit_stat | hit_own | hit_buf | hit_ist | hit_msk;
    wire        wr_w     = access_w & pwrite_i;
    wire        rd_w     = access_w & ~pwrite_i;

    wire        en_w     = ctrl_r[icg_pkg::B_CTL_EN];
    wire        master_w = en_w & ctrl_r[icg_pkg::B_CTL_MASTER];
    wire        slave_w  = en_w & ~ctrl_r[icg_pkg::B_CTL_MASTER];
    wire        tenbit_w = ctrl_r[icg_pkg::B_CTL_TENBIT];

    // master engine state
    icg_pkg::icg_mstate_t m_state_r;
    logic [15:0]          q_cnt_r;
    logic [1:0]           m_ph_r;
    logic [3:0]           m_bit_r;
    logic [7:0]           m_sr_r;
    logic                 m_scl_low_r;
    logic                 m_sda_low_r;

    wire m_busy_w = m_state_r != icg_pkg::M_IDLE;
    wire tick_w   = m_busy_w & (q_cnt_r == 16'(icg_pkg::QTR_CYC - 1));

    // launch requests, accepted only when idle in master mode
    wire con2_wr_w = wr_w & hit_con2;
    wire can_go_w  = master_w & ~m_busy_w;
    wire go_sen_w  = con2_wr_w & can_go_w & pwdata_i[icg_pkg::B_SEN];
    wire go_repeated_start_enable_w = con2_wr_w & can_go_w & pwdata_i[icg_pkg::B_REPEATED_START_ENABLE] & ~pwdata_i[icg_pkg::B_SEN];
    wire go_pen_w  = con2_wr_w & can_go_w & pwdata_i[icg_pkg::B_PEN] & ~|pwdata_i[1:0];
    wire go_master_receive_enable_w = con2_wr_w & can_go_w & pwdata_i[icg_pkg::B_MASTER_RECEIVE_ENABLE] & ~|pwdata_i[2:0];
    wire go_ack_sequence_enable_w = con2_wr_w & can_go_w & pwdata_i[icg_pkg::B_ACK_SEQUENCE_ENABLE] & ~|pwdata_i[3:0];
    wire go_tx_w   = wr_w & hit_buf & can_go_w;

    // end-of-operation points of the master
    wire m_last_ph_w = tick_w & (m_ph_r == 2'd3);
    wire m_done_w    = (tick_w & (m_state_r == icg_pkg::M_START || m_state_r == icg_pkg::M_STOP)
                                & (m_ph_r == 2'd2))
                     | (m_last_ph_w & (m_state_r == icg_pkg::M_RSTART))
                     | (m_last_ph_w & (m_state_r == icg_pkg::M_TX) & (m_bit_r == 4'd8))
                     | (m_last_ph_w & (m_state_r == icg_pkg::M_RX) & (m_bit_r == 4'd7))
                     | (m_last_ph_w & (m_state_r == icg_pkg::M_ACK));
    wire m_sample_w  = tick_w & (m_ph_r == 2'd2);
    wire m_rx_load_w = m_done_w & (m_state_r == icg_pkg::M_RX);

    // link input synchronisers and edge finder
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic       scl_prev_r;
    logic       sda_prev_r;
    wire scl_w      = scl_sync_r[1];
    wire sda_w      = sda_sync_r[1];
    wire scl_rise_w = scl_w & ~scl_prev_r;
    wire scl_fall_w = ~scl_w & scl_prev_r;
    wire start_det_w = en_w & scl_w & scl_prev_r & sda_prev_r & ~sda_w;
    wire stop_det_w  = en_w & scl_w & scl_prev_r & ~sda_prev_r & sda_w;

    // slave engine state
    icg_pkg::icg_sstate_t s_state_r;
    logic [3:0]           s_cnt_r;
    logic [7:0]           s_sr_r;
    logic                 s_ack_r;

    // address comparison after eight bits
    wire s_addr_w  = s_state_r == icg_pkg::S_ADDR;
    wire gc_hit_w  = s_addr_w & con2_r[icg_pkg::B_GENERAL_CALL_ENABLE] & (s_sr_r == icg_pkg::GEN_CALL_ADDR);
    wire own7_w    = s_addr_w & ~tenbit_w & (s_sr_r[7:1] == own_r[7:1]) & ~s_sr_r[0];
    wire ten_hi_w  = s_addr_w & tenbit_w & (s_sr_r[7:3] == icg_pkg::TEN_BIT_HDR)
                   & (s_sr_r[2:1] == own_r[2:1]) & ~s_sr_r[0];
    wire ten_lo_w  = (s_state_r == icg_pkg::S_ADDR2) & (s_sr_r == own_r);
    wire s_data_w  = s_state_r == icg_pkg::S_DATA;
    wire s_match_w = gc_hit_w | own7_w | ten_hi_w | ten_lo_w | s_data_w;
    wire s_eighth_w = slave_w & scl_fall_w & (s_cnt_r == 4'd8) & (s_state_r != icg_pkg::S_IDLE);
    wire s_ninth_w  = slave_w & scl_fall_w & (s_cnt_r == 4'd9);
    wire s_load_w   = s_eighth_w & s_match_w;

    // event sources for the sticky interrupt bits
    wire [icg_pkg::IRQ_W-1:0] irq_set_w = {master_w & stop_det_w,
                                           master_w & start_det_w,
                                           (m_done_w & master_w) | (s_ninth_w & s_ack_r)};
    wire [icg_pkg::IRQ_W-1:0] irq_clr_w = (wr_w & hit_ist) ? pwdata_i[icg_pkg::IRQ_W-1:0]
                                                           : {icg_pkg::IRQ_W{1'b0}};
    wire bf_clr_w = rd_w & hit_buf;

    // read data multiplexer
    wire [7:0] con2_rd_w = {con2_r[icg_pkg::B_GENERAL_CALL_ENABLE], con2_r[icg_pkg::B_ACKST], con2_r[icg_pkg::B_ACK_DATA_VALUE],
                            m_state_r == icg_pkg::M_ACK, m_state_r == icg_pkg::M_RX,
                            m_state_r == icg_pkg::M_STOP, m_state_r == icg_pkg::M_RSTART,
                            m_state_r == icg_pkg::M_START};
    wire [7:0] stat_rd_w = {2'b00, gchit_r, m_busy_w, st_stop_r, st_start_r, ua_r, bf_r};
    wire [31:0] rd_mux_w = hit_con2 ? {24'h0, con2_rd_w} :
                           hit_ctrl ? {29'h0, ctrl_r} :
                           hit_stat ? {24'h0, stat_rd_w} :
                           hit_own  ? {24'h0, own_r} :
                           hit_buf  ? {24'h0, buf_r} :
                           hit_ist  ? {29'h0, irq_r} :
                           hit_msk  ? {29'h0, mask_r} : 32'h0;

    // apb answer: zero wait states, read data captured in setup
    assign pready_o  = 1'b1;
    assign pslverr_o = access_w & ~mapped_w;
    assign prdata_o  = prdata_r;
    assign irq_o     = |(irq_r & mask_r);

    // open-drain link drive: only ever pull low
    assign serial_clock_line_o    = 1'b0;
    assign serial_data_line_o     = 1'b0;
    assign serial_clock_line_oe_o = m_scl_low_r;
    assign serial_data_line_oe_o  = m_sda_low_r | s_ack_r;

    // read data capture
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            prdata_r <= 32'h0;
        end else if (setup_w) begin
            prdata_r <= rd_mux_w;
        end
    end

    // synchronisers, second stage feeds the edge finder
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            scl_sync_r <= 2'b11;
            sda_sync_r <= 2'b11;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], serial_clock_line_i};
            sda_sync_r <= {sda_sync_r[0], serial_data_line_i};
            scl_prev_r <= scl_w;
            sda_prev_r <= sda_w;
        end
    end

    // software registers and flags, set wins over clear
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            con2_r     <= icg_pkg::RST_CON2;
            ctrl_r     <= icg_pkg::RST_CTRL;
            own_r      <= icg_pkg::RST_OWN;
            mask_r     <= icg_pkg::RST_MASK;
            irq_r      <= '0;
            st_start_r <= 1'b0;
            st_stop_r  <= 1'b0;
        end else begin
            if (con2_wr_w) begin
                con2_r[icg_pkg::B_GENERAL_CALL_ENABLE]  <= pwdata_i[icg_pkg::B_GENERAL_CALL_ENABLE];
                con2_r[icg_pkg::B_ACK_DATA_VALUE] <= pwdata_i[icg_pkg::B_ACK_DATA_VALUE];
            end
            if (m_sample_w && m_state_r == icg_pkg::M_TX && m_bit_r == 4'd8) begin
                con2_r[icg_pkg::B_ACKST] <= sda_w;
            end
            if (wr_w && hit_ctrl) ctrl_r <= pwdata_i[2:0];
            if (wr_w && hit_own)  own_r  <= pwdata_i[7:0];
            if (wr_w && hit_msk)  mask_r <= pwdata_i[icg_pkg::IRQ_W-1:0];
            irq_r <= (irq_r & ~irq_clr_w) | irq_set_w;
            // bus condition bits, cleared while disabled
            if (!en_w) begin
                st_start_r <= 1'b0;
                st_stop_r  <= 1'b0;
            end else if (start_det_w) begin
                st_start_r <= 1'b1;
                st_stop_r  <= 1'b0;
            end else if (stop_det_w) begin
                st_start_r <= 1'b0;
                st_stop_r  <= 1'b1;
            end
        end
    end

    // data buffer and buffer-related status
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            buf_r   <= icg_pkg::RST_BUF;
            bf_r    <= 1'b0;
            ua_r    <= 1'b0;
            gchit_r <= 1'b0;
        end else begin
            if (s_load_w) begin
                buf_r <= s_sr_r;
            end else if (m_rx_load_w) begin
                buf_r <= m_sr_r;
            end else if (go_tx_w) begin
                buf_r <= pwdata_i[7:0];
            end
            bf_r <= (bf_r & ~bf_clr_w) | s_load_w | m_rx_load_w;
            if (s_load_w && (ten_hi_w || ten_lo_w)) begin
                ua_r <= 1'b1;
            end else if (wr_w && hit_own) begin
                ua_r <= 1'b0;
            end
            if (s_eighth_w && s_addr_w) gchit_r <= gc_hit_w;
        end
    end

    // master sequencer: quarter-period phases of each bit
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            m_state_r   <= icg_pkg::M_IDLE;
            q_cnt_r     <= 16'h0;
            m_ph_r      <= 2'd0;
            m_bit_r     <= 4'd0;
            m_sr_r      <= 8'h00;
            m_scl_low_r <= 1'b0;
            m_sda_low_r <= 1'b0;
        end else if (!master_w) begin
            m_state_r   <= icg_pkg::M_IDLE;
            q_cnt_r     <= 16'h0;
            m_scl_low_r <= 1'b0;
            m_sda_low_r <= 1'b0;
        end else if (!m_busy_w) begin
            q_cnt_r <= 16'h0;
            m_ph_r  <= 2'd0;
            m_bit_r <= 4'd0;
            if (go_sen_w)        m_state_r <= icg_pkg::M_START;
            else if (go_repeated_start_enable_w)  m_state_r <= icg_pkg::M_RSTART;
            else if (go_pen_w)   m_state_r <= icg_pkg::M_STOP;
            else if (go_master_receive_enable_w)  m_state_r <= icg_pkg::M_RX;
            else if (go_ack_sequence_enable_w) m_state_r <= icg_pkg::M_ACK;
            else if (go_tx_w) begin
                m_state_r <= icg_pkg::M_TX;
                m_sr_r    <= pwdata_i[7:0];
            end
        end else begin
            q_cnt_r <= tick_w ? 16'h0 : q_cnt_r + 16'h1;
            if (tick_w) begin
                m_ph_r <= m_ph_r + 2'd1;
                case (m_state_r)
                    icg_pkg::M_START: begin
                        case (m_ph_r)
                            2'd0:    m_sda_low_r <= 1'b0;
                            2'd1:    m_sda_low_r <= 1'b1;
                            default: m_scl_low_r <= 1'b1;
                        endcase
                    end
                    icg_pkg::M_STOP: begin
                        case (m_ph_r)
                            2'd0:    m_sda_low_r <= 1'b1;
                            2'd1:    m_scl_low_r <= 1'b0;
                            default: m_sda_low_r <= 1'b0;
                        endcase
                    end
                    icg_pkg::M_RSTART: begin
                        case (m_ph_r)
                            2'd0:    m_sda_low_r <= 1'b0;
                            2'd1:    m_scl_low_r <= 1'b0;
                            2'd2:    m_sda_low_r <= 1'b1;
                            default: m_scl_low_r <= 1'b1;
                        endcase
                    end
                    default: begin
                        // one data bit: set data, raise clock, sample, lower clock
                        case (m_ph_r)
                            2'd0: begin
                                if (m_state_r == icg_pkg::M_TX)
                                    m_sda_low_r <= (m_bit_r != 4'd8) & ~m_sr_r[7];
                                else if (m_state_r == icg_pkg::M_ACK)
                                    m_sda_low_r <= ~con2_r[icg_pkg::B_ACK_DATA_VALUE];
                                else
                                    m_sda_low_r <= 1'b0;
                            end
                            2'd1: m_scl_low_r <= 1'b0;
                            2'd2: begin
                                if (m_state_r == icg_pkg::M_RX) m_sr_r <= {m_sr_r[6:0], sda_w};
                            end
                            default: begin
                                m_scl_low_r <= 1'b1;
                                m_bit_r     <= m_bit_r + 4'd1;
                                if (m_state_r == icg_pkg::M_TX) m_sr_r <= {m_sr_r[6:0], 1'b0};
                            end
                        endcase
                    end
                endcase
                if (m_done_w) begin
                    m_state_r <= icg_pkg::M_IDLE;
                    if (m_state_r == icg_pkg::M_RX || m_state_r == icg_pkg::M_ACK)
                        m_sda_low_r <= 1'b0;
                end
            end
        end
    end

    // slave receiver: address match, acknowledge, data bytes
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            s_state_r <= icg_pkg::S_IDLE;
            s_cnt_r   <= 4'd0;
            s_sr_r    <= 8'h00;
            s_ack_r   <= 1'b0;
        end else if (!slave_w) begin
            s_state_r <= icg_pkg::S_IDLE;
            s_ack_r   <= 1'b0;
        end else if (start_det_w) begin
            s_state_r <= icg_pkg::S_ADDR;
            s_cnt_r   <= 4'd0;
            s_ack_r   <= 1'b0;
        end else if (stop_det_w) begin
            s_state_r <= icg_pkg::S_IDLE;
            s_ack_r   <= 1'b0;
        end else if (s_state_r != icg_pkg::S_IDLE) begin
            if (scl_rise_w && s_cnt_r < 4'd8) begin
                s_sr_r  <= {s_sr_r[6:0], sda_w};
                s_cnt_r <= s_cnt_r + 4'd1;
            end else if (s_eighth_w) begin
                s_cnt_r <= 4'd9;
                s_ack_r <= s_match_w;
                if (gc_hit_w || own7_w || ten_lo_w)
                    s_state_r <= icg_pkg::S_DATA;
                else if (ten_hi_w)
                    s_state_r <= icg_pkg::S_ADDR2;
                else if (!s_data_w)
                    s_state_r <= icg_pkg::S_IDLE;
            end else if (s_ninth_w) begin
                s_cnt_r <= 4'd0;
                s_ack_r <= 1'b0;
            end
        end
    end
endmodule : icg_core

// File: tb/icg_properties.sv
`timescale 1ns/1ps
module icg_props_chk (
    // clock, reset and apb
    input wire logic        mclk_i,
    input wire logic        reset_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [15:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // link and interrupt
    input wire logic        serial_clock_line_i,
    input wire logic        serial_clock_line_oe_o,
    input wire logic        serial_data_line_o,
    input wire logic        serial_data_line_oe_o,
    input wire logic        irq_o
);
    // access phase and mapped index window
    wire acc_w = psel_i && penable_i;
    wire map_w = (paddr_i[15:2] >= 14'h0FC0) && (paddr_i[15:2] <= 14'h0FC6);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    a_ready_high: assert property (pready_o) else $error("pready low");
    a_err_access: assert property (pslverr_o |-> acc_w) else $error("pslverr outside access");
    a_map_ok: assert property (acc_w && map_w |-> !pslverr_o) else $error("error on mapped index");
    a_unmap_err: assert property (acc_w && !map_w |-> pslverr_o) else $error("no error on unmapped index");
    a_drive_low: assert property (!serial_data_line_o) else $error("data line driven high");
    a_rdata_hold: assert property (acc_w |=> $stable(prdata_o)) else $error("read data moved");
    a_mask_quiet: assert property (acc_w && pwrite_i && paddr_i[15:2] == 14'h0FC6 && pwdata_i[2:0] == 3'h0
        |=> !irq_o) else $error("irq with all masked");
    a_start_clock: assert property ($rose(serial_data_line_oe_o) && serial_clock_line_i
        |-> ##[1:120] serial_clock_line_oe_o) else $error("clock not pulled after start");
endmodule : icg_props_chk
bind icg_core icg_props_chk u_props (.*);

// File: tb/icg_partner.sv
`timescale 1ns/1ps
module icg_partner (
    // open-drain link, enable high pulls low
    input  wire logic scl_i,
    input  wire logic sda_i,
    input  wire logic ack_i,
    output logic      scl_oe_o,
    output logic      sda_oe_o
);
    logic m_sda = 1'b0;
    logic s_sda = 1'b0;
    int   cnt   = 0;
    initial scl_oe_o = 1'b0;
    assign sda_oe_o = m_sda | s_sda;
    // slave side: count bits after a start, acknowledge the eighth
    always @(negedge sda_i) if (scl_i) cnt = 0;
    always @(posedge scl_i) cnt = cnt + 1;
    always @(negedge scl_i) begin
        s_sda = (cnt == 8) && ack_i;
        if (cnt == 9) cnt = 0;
    end
    // master side, 200 ns link clock
    task automatic start_c();
        m_sda = 1'b1;
        #100 scl_oe_o = 1'b1;
        #100;
    endtask : start_c
    task automatic byte_out(input logic [7:0] d, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            m_sda = (i > 0) ? !d[i-1] : 1'b0;
            #100 scl_oe_o = 1'b0;
            #100 ack = !sda_i;
            scl_oe_o = 1'b1;
        end
    endtask : byte_out
    task automatic stop_c();
        m_sda = 1'b1;
        #100 scl_oe_o = 1'b0;
        #100 m_sda = 1'b0;
        #100;
    endtask : stop_c
endmodule : icg_partner

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic mclk_i = 1'b0, reset_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ack_en = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000, prdata, q, lfsr = 32'h0000F11E;
    logic [7:0]  d, exp_buf;
    logic        pready, pslverr, scl_oe, sda_oe, p_scl, p_sda, irq, a, err;
    int          n_errors = 0, num_checks = 0;
    localparam logic [7:0] TBL [5][5] = '{'{8'h80, 8'h01, 8'h00, 8'h01, 8'h20}, '{8'h80, 8'h01, 8'hA4, 8'h01, 8'h00},
        '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00}, '{8'h80, 8'h05, 8'h00, 8'h01, 8'h20}, '{8'h80, 8'h05, 8'hF4, 8'h01, 8'h02}};
    localparam logic [7:0] SEQ [4] = '{8'h08, 8'h10, 8'h02, 8'h04};
    // pulled-up wires
    wire scl = !(scl_oe | p_scl);
    wire sda = !(sda_oe | p_sda);
    initial forever #12.5 mclk_i = !mclk_i;
    icg_core DUT (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .serial_clock_line_i(scl), .serial_clock_line_o(), .serial_clock_line_oe_o(scl_oe),
        .serial_data_line_i(sda), .serial_data_line_o(), .serial_data_line_oe_o(sda_oe), .irq_o(irq));
    icg_partner P (.scl_i(scl), .sda_i(sda), .ack_i(ack_en), .scl_oe_o(p_scl), .sda_oe_o(p_sda));
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction : rnd
    task automatic results();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // apb transfer, result settled at the following falling edge
    task automatic apb(input logic w, input logic [11:0] i, input logic [7:0] v);
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= {24'h000000, v};
        @(posedge mclk_i);
        penable <= 1'b1;
        repeat (20) begin
            @(posedge mclk_i);
            if (pready === 1'b1) break;
        end
        if (pready !== 1'b1) n_errors++;
        if (pready !== 1'b1) results();
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge mclk_i);
    endtask : apb
    task automatic wclr(input logic [11:0] i, input logic [7:0] m);
        repeat (3000) begin
            apb(1'b0, i, 8'h00);
            if ((q[7:0] & m) === 8'h00) return;
        end
        n_errors++;
        results();
    endtask : wclr
    // main sequence
    initial begin
        repeat (10) @(posedge mclk_i);
        reset_i <= 1'b0;
        apb(1'b0, icg_pkg::IDX_CON2, 8'h00);
        chk("con2 reset", {24'h000000, icg_pkg::RST_CON2}, q);
        apb(1'b0, 12'hFC7, 8'h00);
        chk("unmapped", 32'h00000001, {31'h00000000, err});
        apb(1'b1, icg_pkg::IDX_OWN_ADDR, 8'hA4);
        apb(1'b1, icg_pkg::IDX_INT_MASK, 8'h07);
        foreach (TBL[k]) begin
            apb(1'b1, icg_pkg::IDX_CTRL, TBL[k][1]);
            apb(1'b1, icg_pkg::IDX_CON2, TBL[k][0]);
            P.start_c();
            P.byte_out(TBL[k][2], a);
            chk("addr ack", {24'h000000, TBL[k][3]}, {31'h00000000, a});
            if (a) exp_buf = TBL[k][2];
            if (k == 3) d = rnd();
            if (k == 3) P.byte_out(d, a);
            if (k == 3) exp_buf = d;
            P.stop_c();
            chk("irq", {31'h00000000, TBL[k][3][0]}, {31'h00000000, irq});
            apb(1'b0, icg_pkg::IDX_STAT, 8'h00);
            chk("status", {24'h000000, TBL[k][4]}, q & 32'h00000022);
            apb(1'b0, icg_pkg::IDX_BUF, 8'h00);
            chk("buffer", {24'h000000, exp_buf}, q);
            apb(1'b1, icg_pkg::IDX_INT_STAT, 8'h07);
            chk("irq clear", 32'h00000000, {31'h00000000, irq});
        end
        $display("slave tests done");
        apb(1'b1, icg_pkg::IDX_CTRL, 8'h03);
        apb(1'b1, icg_pkg::IDX_CON2, 8'h81);
        wclr(icg_pkg::IDX_CON2, 8'h01);
        for (int k = 0; k < 2; k++) begin
            ack_en = (k == 0);
            apb(1'b1, icg_pkg::IDX_BUF, rnd());
            apb(1'b1, icg_pkg::IDX_CON2, 8'h01);
            apb(1'b0, icg_pkg::IDX_CON2, 8'h00);
            chk("busy start", 32'h00000000, q & 32'h00000001);
            wclr(icg_pkg::IDX_STAT, 8'h10);
            apb(1'b0, icg_pkg::IDX_CON2, 8'h00);
            chk("ack status", (k == 0) ? 32'h00000000 : 32'h00000040, q & 32'h00000040);
        end
        ack_en = 1'b0;
        foreach (SEQ[k]) begin
            apb(1'b1, icg_pkg::IDX_CON2, SEQ[k]);
            wclr(icg_pkg::IDX_CON2, SEQ[k]);
        end
        apb(1'b0, icg_pkg::IDX_BUF, 8'h00);
        chk("rx byte", 32'h000000FF, q);
        apb(1'b0, icg_pkg::IDX_STAT, 8'h00);
        chk("stop seen", 32'h00000008, q & 32'h00000008);
        chk("stop irq", 32'h00000001, {31'h00000000, irq});
        apb(1'b1, icg_pkg::IDX_CTRL, 8'h00);
        apb(1'b0, icg_pkg::IDX_STAT, 8'h00);
        chk("status off", 32'h00000000, q & 32'h0000000C);
        apb(1'b1, icg_pkg::IDX_INT_MASK, 8'h00);
        $display("master tests done");
        results();
    end
endmodule : tb
